// ### shared/lsd_display_regs.svh
/*
  Register numbers, reset values, character codes and timing figures of
  the front-panel display controller. Definitions only. Assumes it is
  included by bare name from the package and from the design file.
*/
`ifndef LSD_DISPLAY_REGS_SVH
`define LSD_DISPLAY_REGS_SVH

// Host register numbers, as seen on the Modbus register port.
`define LSD_REG_UNIT      16'h0fb4
`define LSD_REG_DECIMAL   16'h0fb5
`define LSD_REG_UNIT2     16'h0fb7
`define LSD_REG_VAL2_PTR  16'h0fb8
`define LSD_REG_SAVE      16'h0fed
`define LSD_REG_GLYPH     16'h1130
`define LSD_GLYPH_ROWS    16'h0028
`define LSD_GLYPH_LINES   3'h7

// Reset values and field limits.
`define LSD_RST_UNIT      16'h0000
`define LSD_RST_DECIMAL   16'h0000
`define LSD_RST_UNIT2     16'h0000
`define LSD_RST_VAL2_PTR  16'h1d5b
`define LSD_UNIT_CUSTOM   16'h0039
`define LSD_DP_AUTO       16'h0000
`define LSD_GLYPH_W       5

// Character codes; codes 0 to 4 address the custom glyph cells.
`define LSD_CH_SPACE      8'h20
`define LSD_CH_MINUS      8'h2d
`define LSD_CH_DOT        8'h2e
`define LSD_CH_COLON      8'h3a
`define LSD_CH_ZERO       8'h30
`define LSD_CH_UNDER      8'h56
`define LSD_CH_OVER       8'h5e
`define LSD_CH_BAR        8'hff
`define LSD_CH_STORE      8'h05
`define LSD_CH_MAX        8'h06
`define LSD_CH_MIN        8'h07
`define LSD_CH_VAL2       8'h3e
`define LSD_CH_UNIT_BASE  8'h80

// Message texts, eight characters, leftmost in the top byte.
`define LSD_TXT_RESTORE   64'h526573746f726520
`define LSD_TXT_FABR      64'h466162722e506172
`define LSD_TXT_DONE      64'h646f6e6520202020
`define LSD_TXT_RENEW     64'h49502072656e6577
`define LSD_TXT_DHCP      64'h444843503a202020
`define LSD_TXT_CONFIG    64'h436f6e6669672020
`define LSD_TXT_LOAD_OK   64'h46696c65206f6b20
`define LSD_TXT_LOAD_ERR  64'h46696c6520657272

// Timing in its own units and the clock rate.
`define LSD_CLK_KHZ       125000
`define LSD_BLINK_MS      500
`define LSD_DONE_MS       20000
`define LSD_PHASE_MS      2000
`define LSD_BAR_FULL      100

`endif

// ### shared/lsd_display_pkg.sv
/*
  Types shared by the display controller and its bench. Assumes the
  register header sits beside it on the include path.
*/
`include "lsd_display_regs.svh"

package lsd_display_pkg;

  // Lower row functions, one-hot.
  typedef enum logic [4:0] {
    LSD_LM_UNIT = 5'h01,
    LSD_LM_TIME = 5'h02,
    LSD_LM_DATE = 5'h04,
    LSD_LM_BAR  = 5'h08,
    LSD_LM_VAL2 = 5'h10
  } lsd_lower_mode_t;

  // Service message sequencer states, one-hot.
  typedef enum logic [6:0] {
    LSD_MS_NONE     = 7'h01,
    LSD_MS_RESTORE  = 7'h02,
    LSD_MS_DONE     = 7'h04,
    LSD_MS_DHCP     = 7'h08,
    LSD_MS_IP       = 7'h10,
    LSD_MS_LOAD_OK  = 7'h20,
    LSD_MS_LOAD_ERR = 7'h40
  } lsd_msg_state_t;

  // Decimal value: sign and nine BCD digits, the low four are fraction.
  typedef struct packed {
    logic            neg;
    logic [8:0][3:0] dig;
  } lsd_dec_t;

  typedef struct packed {
    logic [7:0] hh;
    logic [7:0] mm;
    logic [7:0] ss;
  } lsd_time_t;

  typedef struct packed {
    logic [7:0] dd;
    logic [7:0] mo;
    logic [7:0] yy;
  } lsd_date_t;

  typedef struct packed {
    logic mounted;
    logic unmounted;
    logic write_prot;
    logic full;
  } lsd_store_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lsd_reg_req_t;

  typedef struct packed {
    logic [7:0][7:0] row0;
    logic [7:0][7:0] row1;
  } lsd_lcd_t;

endpackage

// ### rtl/lsd_display.sv
/*
  Front-panel display controller: builds the two eight-character rows,
  holds the display registers and custom glyph rows, sequences service
  messages and raises the configuration save request.
  Assumes all non-key inputs come from logic on ref_clk; the four keys
  are raw pins, active low. The panel driver reads lcd and glyph_rows.
*/
`timescale 1ns/100ps
`include "lsd_display_regs.svh"

module lsd_display #(
  parameter logic [31:0] BLINK_CYC = 32'(`LSD_BLINK_MS * `LSD_CLK_KHZ)
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rstn,
  input  wire lsd_display_pkg::lsd_reg_req_t  reg_req,
  output logic [15:0]                         reg_rdata,
  input  wire logic                           key_up_n,
  input  wire logic                           key_down_n,
  input  wire logic                           key_max_n,
  input  wire logic                           key_min_n,
  input  wire lsd_display_pkg::lsd_dec_t      main_val,
  input  wire lsd_display_pkg::lsd_dec_t      max_val,
  input  wire lsd_display_pkg::lsd_dec_t      min_val,
  input  wire logic                           range_under,
  input  wire logic                           range_over,
  input  wire lsd_display_pkg::lsd_store_t    store_stat,
  input  wire lsd_display_pkg::lsd_time_t     rtc_time,
  input  wire lsd_display_pkg::lsd_date_t     rtc_date,
  input  wire logic [6:0]                     aout_pct,
  input  wire lsd_display_pkg::lsd_dec_t      val2,
  input  wire logic                           nv_load,
  input  wire logic [4:0]                     nv_mode,
  input  wire logic                           save_done,
  input  wire logic                           restore_need,
  input  wire logic                           restore_done,
  input  wire logic                           dhcp_renew,
  input  wire logic [31:0]                    ip_addr,
  input  wire logic                           load_done,
  input  wire logic                           load_ok,
  output lsd_display_pkg::lsd_lcd_t           lcd,
  output logic [39:0][4:0]                    glyph_rows,
  output logic [15:0]                         unit_code,
  output logic [15:0]                         val2_reg_num,
  output logic [4:0]                          lower_mode,
  output logic                                save_req
);
  import lsd_display_pkg::*;

  localparam int DONE_TICKS  = `LSD_DONE_MS / `LSD_BLINK_MS;
  localparam int PHASE_TICKS = `LSD_PHASE_MS / `LSD_BLINK_MS;

  logic [15:0]      decimal_r;
  logic [15:0]      unit2_r;
  logic [15:0]      gidx;
  logic             ghit;
  logic [3:0]       key_s1_r;
  logic [3:0]       key_s2_r;
  logic [3:0]       key_q_r;
  logic             up_evt;
  logic             down_evt;
  logic [31:0]      blink_cnt_r;
  logic             blink_r;
  logic             tick_r;
  lsd_lower_mode_t  mode_r;
  lsd_msg_state_t   msg_r;
  logic [7:0]       msg_cnt_r;
  logic [7:0]       ph_cnt_r;
  logic             msg_phase_r;
  lsd_lcd_t         lcd_nxt;

  // Format five digits with an optional point into six characters.
  function automatic logic [5:0][7:0] fmt5(lsd_dec_t v, logic [15:0] dp);
    logic [5:0][7:0] c;
    int              lead;
    int              s;
    int              k;
    logic            dot_next;
    c        = '0;
    lead     = 0;
    k        = 0;
    dot_next = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (v.dig[i] != 4'h0) begin
        lead = i;
      end
    end
    if (dp == `LSD_DP_AUTO) begin
      s = (lead > 4) ? lead : 4;
    end else if (dp > 16'h0004) begin
      s = 4;
    end else begin
      s = 9 - int'(dp);
    end
    k = s;
    for (int p = 0; p < 6; p++) begin
      if (dot_next) begin
        c[5-p]   = `LSD_CH_DOT;
        dot_next = 1'b0;
      end else if (k >= s - 4) begin
        c[5-p] = `LSD_CH_ZERO + {4'h0, v.dig[k]};
        if (k == 4 && s > 4) begin
          dot_next = 1'b1;
        end
        k = k - 1;
      end else begin
        c[5-p] = `LSD_CH_SPACE;
      end
    end
    return c;
  endfunction

  // Two BCD digits become two characters.
  function automatic logic [1:0][7:0] bcd2(logic [7:0] b);
    return {`LSD_CH_ZERO + {4'h0, b[7:4]}, `LSD_CH_ZERO + {4'h0, b[3:0]}};
  endfunction

  // One address byte becomes three decimal characters.
  function automatic logic [2:0][7:0] dec3(logic [7:0] b);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    h = b / 8'h64;
    t = (b / 8'h0a) % 8'h0a;
    o = b % 8'h0a;
    return {`LSD_CH_ZERO + h, `LSD_CH_ZERO + t, `LSD_CH_ZERO + o};
  endfunction

  // Key pins cross into ref_clk through two flops; edges use stage two.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      key_s1_r <= 4'h0;
      key_s2_r <= 4'h0;
      key_q_r  <= 4'h0;
    end else begin
      key_s1_r <= ~{key_min_n, key_max_n, key_down_n, key_up_n};
      key_s2_r <= key_s1_r;
      key_q_r  <= key_s2_r;
    end
  end

  assign up_evt   = key_s2_r[0] & ~key_q_r[0];
  assign down_evt = key_s2_r[1] & ~key_q_r[1];

  // Glyph register window decode; higher numbers fall outside it.
  assign gidx = reg_req.addr - `LSD_REG_GLYPH;
  assign ghit = gidx < `LSD_GLYPH_ROWS;

  // Host writes to the display registers.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      unit_code    <= `LSD_RST_UNIT;
      decimal_r    <= `LSD_RST_DECIMAL;
      unit2_r      <= `LSD_RST_UNIT2;
      val2_reg_num <= `LSD_RST_VAL2_PTR;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `LSD_REG_UNIT:     unit_code    <= reg_req.wdata;
        `LSD_REG_DECIMAL:  decimal_r    <= reg_req.wdata;
        `LSD_REG_UNIT2:    unit2_r      <= reg_req.wdata;
        `LSD_REG_VAL2_PTR: val2_reg_num <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Glyph rows keep five bits only; bit 4 is the leftmost pixel.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      glyph_rows <= '0;
    end else if (reg_req.wr && ghit) begin
      glyph_rows[gidx[5:0]] <= reg_req.wdata[4:0];
    end
  end

  // Save request holds until the file system reports completion; a new
  // write of one in the completion cycle wins so no request is lost.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      save_req <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == `LSD_REG_SAVE &&
                 reg_req.wdata == 16'h0001) begin
      save_req <= 1'b1;
    end else if (save_done) begin
      save_req <= 1'b0;
    end
  end

  // Read data is registered and appears the cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      if (ghit) begin
        reg_rdata <= {11'h000, glyph_rows[gidx[5:0]]};
      end else begin
        case (reg_req.addr)
          `LSD_REG_UNIT:     reg_rdata <= unit_code;
          `LSD_REG_DECIMAL:  reg_rdata <= decimal_r;
          `LSD_REG_UNIT2:    reg_rdata <= unit2_r;
          `LSD_REG_VAL2_PTR: reg_rdata <= val2_reg_num;
          `LSD_REG_SAVE:     reg_rdata <= {15'h0000, save_req};
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Blink time base; its tick also paces the message sequencer.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= 1'b0;
      tick_r      <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYC - 32'h1) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= ~blink_r;
      tick_r      <= 1'b1;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
      tick_r      <= 1'b0;
    end
  end

  // Lower row function; the stored copy wins after power returns.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mode_r <= LSD_LM_UNIT;
    end else if (nv_load) begin
      case (nv_mode)
        5'h02:   mode_r <= LSD_LM_TIME;
        5'h04:   mode_r <= LSD_LM_DATE;
        5'h08:   mode_r <= LSD_LM_BAR;
        5'h10:   mode_r <= LSD_LM_VAL2;
        default: mode_r <= LSD_LM_UNIT;
      endcase
    end else if (up_evt && !down_evt) begin
      mode_r <= lsd_lower_mode_t'({mode_r[3:0], mode_r[4]});
    end else if (down_evt && !up_evt) begin
      mode_r <= lsd_lower_mode_t'({mode_r[0], mode_r[4:1]});
    end
  end

  assign lower_mode = mode_r;

  // Message alternation phase, restarted by each restore-done, DHCP renew or load event.
  always_ff @(posedge ref_clk) begin
    if (!rstn || restore_done || dhcp_renew || load_done) begin
      ph_cnt_r    <= 8'h0;
      msg_phase_r <= 1'b1;
    end else if (tick_r) begin
      if (ph_cnt_r >= 8'(PHASE_TICKS - 1)) begin
        ph_cnt_r    <= 8'h0;
        msg_phase_r <= ~msg_phase_r;
      end else begin
        ph_cnt_r <= ph_cnt_r + 8'h1;
      end
    end
  end

  // Service message sequencer; load, DHCP renew and restore-done events take the display, in that priority; a restore need only from idle.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      msg_r     <= LSD_MS_NONE;
      msg_cnt_r <= 8'h0;
    end else if (load_done) begin
      msg_r     <= load_ok ? LSD_MS_LOAD_OK : LSD_MS_LOAD_ERR;
      msg_cnt_r <= 8'h0;
    end else if (dhcp_renew) begin
      msg_r     <= LSD_MS_DHCP;
      msg_cnt_r <= 8'h0;
    end else if (restore_done) begin
      msg_r     <= LSD_MS_DONE;
      msg_cnt_r <= 8'h0;
    end else begin
      if (tick_r) begin
        msg_cnt_r <= msg_cnt_r + 8'h1;
      end
      case (msg_r)
        LSD_MS_NONE: begin
          if (restore_need) begin
            msg_r <= LSD_MS_RESTORE;
          end
        end
        LSD_MS_RESTORE: begin
          if (!restore_need) begin
            msg_r <= LSD_MS_NONE;
          end
        end
        LSD_MS_DONE, LSD_MS_LOAD_OK, LSD_MS_LOAD_ERR: begin
          if (tick_r && msg_cnt_r >= 8'(DONE_TICKS - 1)) begin
            msg_r <= LSD_MS_NONE;
          end
        end
        LSD_MS_DHCP: begin
          if (tick_r && msg_cnt_r >= 8'(PHASE_TICKS - 1)) begin
            msg_r     <= LSD_MS_IP;
            msg_cnt_r <= 8'h0;
          end
        end
        LSD_MS_IP: begin
          if (tick_r && msg_cnt_r >= 8'(PHASE_TICKS - 1)) begin
            msg_r <= LSD_MS_NONE;
          end
        end
        default: msg_r <= LSD_MS_NONE;
      endcase
    end
  end

  // Character assembly for both rows. Leftmost character is index 7.
  always_comb begin
    lsd_dec_t        top_v;
    logic [5:0][7:0] num;
    logic [5:0][7:0] num2;
    logic            blink_stat;
    top_v      = main_val;
    num        = '0;
    num2       = '0;
    blink_stat = store_stat.unmounted | store_stat.write_prot |
                 store_stat.full;
    lcd_nxt.row0 = {8{`LSD_CH_SPACE}};
    lcd_nxt.row1 = {8{`LSD_CH_SPACE}};
    if (key_s2_r[2]) begin
      top_v = max_val;
    end else if (key_s2_r[3]) begin
      top_v = min_val;
    end
    num = fmt5(top_v, decimal_r);
    // Top row: sign, number or fill, then the pictogram cell.
    if (range_under) begin
      lcd_nxt.row0[6:1] = {6{`LSD_CH_UNDER}};
    end else if (range_over) begin
      lcd_nxt.row0[6:1] = {6{`LSD_CH_OVER}};
    end else begin
      lcd_nxt.row0[7]   = top_v.neg ? `LSD_CH_MINUS : `LSD_CH_SPACE;
      lcd_nxt.row0[6:1] = num;
    end
    if (key_s2_r[2]) begin
      lcd_nxt.row0[0] = `LSD_CH_MAX;
    end else if (key_s2_r[3]) begin
      lcd_nxt.row0[0] = `LSD_CH_MIN;
    end else if (blink_stat) begin
      lcd_nxt.row0[0] = blink_r ? `LSD_CH_STORE : `LSD_CH_SPACE;
    end else if (store_stat.mounted) begin
      lcd_nxt.row0[0] = `LSD_CH_STORE;
    end
    // Lower row by the selected function.
    case (mode_r)
      LSD_LM_UNIT: begin
        if (unit_code == `LSD_UNIT_CUSTOM) begin
          lcd_nxt.row1[7:3] = {8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
        end else begin
          lcd_nxt.row1[7] = `LSD_CH_UNIT_BASE + {1'b0, unit_code[6:0]};
        end
      end
      LSD_LM_TIME: begin
        lcd_nxt.row1 = {bcd2(rtc_time.hh), `LSD_CH_COLON,
                        bcd2(rtc_time.mm), `LSD_CH_COLON,
                        bcd2(rtc_time.ss)};
      end
      LSD_LM_DATE: begin
        lcd_nxt.row1 = {bcd2(rtc_date.dd), `LSD_CH_COLON,
                        bcd2(rtc_date.mo), `LSD_CH_COLON,
                        bcd2(rtc_date.yy)};
      end
      LSD_LM_BAR: begin
        for (int i = 0; i < 8; i++) begin
          if (int'(aout_pct) * 8 >= (i + 1) * `LSD_BAR_FULL) begin
            lcd_nxt.row1[7-i] = `LSD_CH_BAR;
          end
        end
      end
      LSD_LM_VAL2: begin
        num2              = fmt5(val2, `LSD_DP_AUTO);
        lcd_nxt.row1[7]   = val2.neg ? `LSD_CH_MINUS : `LSD_CH_VAL2;
        lcd_nxt.row1[6:1] = num2;
        lcd_nxt.row1[0]   = `LSD_CH_UNIT_BASE + {1'b0, unit2_r[6:0]};
      end
      default: ;
    endcase
    // Service messages; restore texts alternate with measurements.
    case (msg_r)
      LSD_MS_RESTORE: begin
        if (msg_phase_r) begin
          lcd_nxt.row0 = `LSD_TXT_RESTORE;
          lcd_nxt.row1 = `LSD_TXT_FABR;
        end
      end
      LSD_MS_DONE: begin
        if (msg_phase_r) begin
          lcd_nxt.row0 = `LSD_TXT_FABR;
          lcd_nxt.row1 = `LSD_TXT_DONE;
        end
      end
      LSD_MS_DHCP: begin
        lcd_nxt.row0 = `LSD_TXT_RENEW;
        lcd_nxt.row1 = `LSD_TXT_DHCP;
      end
      LSD_MS_IP: begin
        lcd_nxt.row0 = {dec3(ip_addr[31:24]), `LSD_CH_DOT,
                        dec3(ip_addr[23:16]), `LSD_CH_DOT};
        lcd_nxt.row1 = {dec3(ip_addr[15:8]), `LSD_CH_DOT,
                        dec3(ip_addr[7:0]), `LSD_CH_SPACE};
      end
      LSD_MS_LOAD_OK: begin
        lcd_nxt.row0 = `LSD_TXT_CONFIG;
        lcd_nxt.row1 = `LSD_TXT_LOAD_OK;
      end
      LSD_MS_LOAD_ERR: begin
        lcd_nxt.row0 = `LSD_TXT_CONFIG;
        lcd_nxt.row1 = `LSD_TXT_LOAD_ERR;
      end
      default: ;
    endcase
  end

  // Rows are registered so the panel driver sees stable characters.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lcd.row0 <= {8{`LSD_CH_SPACE}};
      lcd.row1 <= {8{`LSD_CH_SPACE}};
    end else begin
      lcd <= lcd_nxt;
    end
  end

endmodule

// ### verification/lsd_display_asserts.sv
/*
  Checker for the display controller, bound to its top-level ports.
  Assumes one clock, ref_clk, and a synchronous active-low rstn.
*/
`timescale 1ns/100ps
`include "lsd_display_regs.svh"
module lsd_display_asserts
  import lsd_display_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          rstn,
  input wire lsd_display_pkg::lsd_reg_req_t reg_req,
  input wire logic [15:0]                   reg_rdata,
  input wire logic                          key_up_n,
  input wire logic                          key_down_n,
  input wire logic                          nv_load,
  input wire logic                          range_under,
  input wire logic                          range_over,
  input wire logic                          save_done,
  input wire lsd_display_pkg::lsd_lcd_t     lcd,
  input wire logic [39:0][4:0]              glyph_rows,
  input wire logic [15:0]                   unit_code,
  input wire logic [15:0]                   val2_reg_num,
  input wire logic [4:0]                    lower_mode,
  input wire logic                          save_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Mode after one up step, kept so the key check can look back.
  logic [4:0] rot_up;
  assign rot_up = {lower_mode[3:0], lower_mode[4]};
  sequence s_save_wr;
    reg_req.wr && reg_req.addr == `LSD_REG_SAVE && reg_req.wdata == 16'h1;
  endsequence
  // Up alone held for four cycles, no restore of the stored mode.
  sequence s_up;
    $fell(key_up_n) && key_down_n
      ##1 (!key_up_n && key_down_n && !nv_load)[*4];
  endsequence
  property p_save_set; s_save_wr |=> save_req; endproperty
  property p_save_clr; save_done && !reg_req.wr |=> !save_req; endproperty
  property p_unit;
    reg_req.wr && reg_req.addr == `LSD_REG_UNIT
      |=> unit_code == $past(reg_req.wdata);
  endproperty
  property p_ptr;
    reg_req.wr && reg_req.addr == `LSD_REG_VAL2_PTR
      |=> val2_reg_num == $past(reg_req.wdata);
  endproperty
  property p_glyph;
    reg_req.wr && reg_req.addr == `LSD_REG_GLYPH + 16'h27
      |=> glyph_rows[39] == $past(reg_req.wdata[4:0]);
  endproperty
  property p_rd_unit;
    reg_req.rd && !reg_req.wr && reg_req.addr == `LSD_REG_UNIT
      |=> reg_rdata == unit_code;
  endproperty
  property p_under; range_under |=> lcd.row0[6:1] == {6{8'h56}}; endproperty
  property p_over;
    range_over && !range_under |=> lcd.row0[6:1] == {6{8'h5e}};
  endproperty
  property p_up; s_up |-> lower_mode == $past(rot_up, 4); endproperty
  a_save_set: assert property (p_save_set) else $error("save not set");
  a_save_clr: assert property (p_save_clr) else $error("save stuck");
  a_unit: assert property (p_unit) else $error("unit not stored");
  a_ptr: assert property (p_ptr) else $error("pointer not stored");
  a_glyph: assert property (p_glyph) else $error("glyph row wrong");
  a_rd_unit: assert property (p_rd_unit) else $error("unit read wrong");
  a_under: assert property (p_under) else $error("under fill wrong");
  a_over: assert property (p_over) else $error("over fill wrong");
  a_up: assert property (p_up) else $error("up step wrong");
endmodule
bind lsd_display lsd_display_asserts u_chk (.ref_clk, .rstn, .reg_req,
  .reg_rdata, .key_up_n, .key_down_n, .nv_load, .range_under, .range_over,
  .save_done, .lcd, .glyph_rows, .unit_code, .val2_reg_num, .lower_mode,
  .save_req);

// ### verification/lsd_panel_model.sv
/*
  Front keys and two-row panel. Keys are pulled up, so a released key
  reads high. Assumes the bench asks for presses through key_cmd.
*/
`timescale 1ns/100ps
module lsd_panel_model
  import lsd_display_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic [3:0]                key_cmd,
  input wire lsd_display_pkg::lsd_lcd_t lcd,
  output logic                          key_up_n,
  output logic                          key_down_n,
  output logic                          key_max_n,
  output logic                          key_min_n,
  output logic [127:0]                  shown
);
  // Pins move on the falling edge so the design never samples a change.
  initial {key_up_n, key_down_n, key_max_n, key_min_n} = 4'hf;
  always @(negedge ref_clk) begin
    {key_up_n, key_down_n, key_max_n, key_min_n} <= ~key_cmd;
  end
  // The glass holds two rows of eight characters.
  assign shown = {lcd.row0, lcd.row1};
endmodule

// ### verification/lsd_display_tb.sv
/*
  Self-checking bench for the display controller. Assumes the panel
  model beside it and a short blink tick so messages finish quickly.
*/
`timescale 1ns/100ps
`include "lsd_display_regs.svh"
module lsd_display_tb;
  import lsd_display_pkg::*;
  logic ref_clk, rstn, und, ovr, nvl, sdone, rneed, rdone, dren, ldone, lok;
  logic ku, kd, kx, kn, sreq;
  lsd_reg_req_t req;
  logic [15:0] rdata, ucode, ptr, d;
  logic [3:0] keys;
  logic [4:0] nvm, mode;
  logic [6:0] pct;
  logic [31:0] ip;
  lsd_dec_t mv;
  lsd_store_t st;
  lsd_time_t tm;
  lsd_date_t dt;
  lsd_lcd_t lcd;
  logic [39:0][4:0] glyph;
  logic [127:0] shown;
  int bad_count, compares, cyc_n, n;
  lsd_display #(.BLINK_CYC(32'd8)) uut (.ref_clk, .rstn, .reg_req(req),
    .reg_rdata(rdata), .key_up_n(ku), .key_down_n(kd), .key_max_n(kx),
    .key_min_n(kn), .main_val(mv), .max_val(mv), .min_val(mv),
    .range_under(und), .range_over(ovr), .store_stat(st), .rtc_time(tm),
    .rtc_date(dt), .aout_pct(pct), .val2(mv), .nv_load(nvl), .nv_mode(nvm),
    .save_done(sdone), .restore_need(rneed), .restore_done(rdone),
    .dhcp_renew(dren), .ip_addr(ip), .load_done(ldone), .load_ok(lok),
    .lcd, .glyph_rows(glyph), .unit_code(ucode), .val2_reg_num(ptr),
    .lower_mode(mode), .save_req(sreq));
  lsd_panel_model u_panel (.ref_clk, .key_cmd(keys), .lcd, .key_up_n(ku),
    .key_down_n(kd), .key_max_n(kx), .key_min_n(kn), .shown);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // Wide enough for both rows at once, so a message compares in full.
  task automatic check(string nm, logic [127:0] got, logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] v);
    @(negedge ref_clk) req = '{1'b1, 1'b0, a, v};
    @(negedge ref_clk) req.wr = 1'b0;
  endtask
  task automatic rd(logic [15:0] a);
    @(negedge ref_clk) req = '{1'b0, 1'b1, a, 16'h0};
    @(negedge ref_clk) req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic press(logic [3:0] k);
    keys = k;
    cyc(7);
    keys = 4'h0;
    cyc(4);
  endtask
  // Waits a bounded time for both rows to show a message.
  task automatic see(string nm, logic [63:0] r0, logic [63:0] r1);
    for (n = 0; n < 200 && shown !== {r0, r1}; n++) cyc(1);
    check(nm, shown, {r0, r1});
  endtask
  task automatic t_regs();
    check("ptr_rst", ptr, 16'h1d5b);
    check("mode_rst", mode, 5'h01);
    wr(`LSD_REG_UNIT, 16'h0039);
    cyc(2);
    check("glyph_unit", lcd.row1[7:3], 40'h0001020304);
    rd(`LSD_REG_UNIT);
    check("unit_rd", d, 16'h0039);
    wr(`LSD_REG_GLYPH + 16'h27, 16'hffe5);
    check("glyph_bits", glyph[39], 5'h05);
    rd(`LSD_REG_GLYPH + 16'h27);
    check("glyph_rd", d, 16'h0005);
    rd(`LSD_REG_GLYPH + 16'h28);
    check("glyph_end", d, 16'h0);
    wr(`LSD_REG_VAL2_PTR, 16'h1d4c);
    check("ptr", ptr, 16'h1d4c);
    wr(`LSD_REG_UNIT2, 16'h0003);
    wr(`LSD_REG_SAVE, 16'h0001);
    check("save_set", sreq, 1'b1);
    sdone = 1'b1;
    cyc(1);
    sdone = 1'b0;
    check("save_clr", sreq, 1'b0);
    $display("t_regs done");
  endtask
  task automatic t_keys();
    tm = '{8'h12, 8'h34, 8'h56};
    dt = '{8'h31, 8'h12, 8'h25};
    pct = 7'd50;
    press(4'h8);
    check("m_time", mode, 5'h02);
    check("time", lcd.row1, 64'h31323a33343a3536);
    press(4'h8);
    check("date", lcd.row1, 64'h33313a31323a3235);
    press(4'h8);
    check("bar", lcd.row1, 64'hffffffff20202020);
    press(4'h8);
    check("unit2", lcd.row1[0], 8'h83);
    press(4'h8);
    check("m_unit", mode, 5'h01);
    press(4'h4);
    check("m_down", mode, 5'h10);
    press(4'hc);
    check("m_both", mode, 5'h10);
    @(negedge ref_clk) {nvl, nvm} = {1'b1, 5'h08};
    @(negedge ref_clk) nvl = 1'b0;
    check("nv_mode", mode, 5'h08);
    $display("t_keys done");
  endtask
  task automatic t_top();
    st = '{1'b1, 1'b0, 1'b0, 1'b0};
    cyc(20);
    check("store_on", lcd.row0[0], 8'h05);
    check("top_auto", lcd.row0, 64'h20313233342e3505);
    wr(`LSD_REG_DECIMAL, 16'h0004);
    cyc(2);
    check("top_dp", lcd.row0[7:1], 56'h2033342e353030);
    keys = 4'h2;
    cyc(6);
    check("max_pic", lcd.row0[0], 8'h06);
    keys = 4'h1;
    cyc(6);
    check("min_pic", lcd.row0[0], 8'h07);
    keys = 4'h0;
    st.full = 1'b1;
    n = 0;
    repeat (40) begin
      cyc(1);
      n += int'(lcd.row0[0] === 8'h05);
    end
    check("blink", n > 8 && n < 30, 1'b1);
    und = 1'b1;
    cyc(2);
    check("under", lcd.row0[6:1], {6{8'h56}});
    {und, ovr} = 2'b01;
    cyc(2);
    check("over", lcd.row0[6:1], {6{8'h5e}});
    ovr = 1'b0;
    $display("t_top done");
  endtask
  task automatic t_msg();
    rneed = 1'b1;
    see("restore", `LSD_TXT_RESTORE, `LSD_TXT_FABR);
    rneed = 1'b0;
    cyc(40);
    rdone = 1'b1;
    cyc(1);
    rdone = 1'b0;
    see("fabr_done", `LSD_TXT_FABR, `LSD_TXT_DONE);
    cyc(400);
    dren = 1'b1;
    cyc(1);
    dren = 1'b0;
    see("dhcp", `LSD_TXT_RENEW, `LSD_TXT_DHCP);
    see("ip", 64'h3139322e3136382e, 64'h3030312e30333020);
    cyc(100);
    {ldone, lok} = 2'b11;
    cyc(1);
    ldone = 1'b0;
    see("load_ok", `LSD_TXT_CONFIG, `LSD_TXT_LOAD_OK);
    cyc(400);
    {ldone, lok} = 2'b10;
    cyc(1);
    ldone = 1'b0;
    see("load_err", `LSD_TXT_CONFIG, `LSD_TXT_LOAD_ERR);
    $display("t_msg done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Inputs start idle; reset spans sixteen clocks.
  initial begin
    {rstn, und, ovr, nvl, sdone, rneed, rdone, dren, ldone, lok} = '0;
    {req, keys, nvm, pct, st, tm, dt} = '0;
    ip = 32'hc0a8011e;
    mv = '{1'b0, 36'h012345000};
    cyc(16);
    rstn = 1'b1;
    t_regs();
    t_keys();
    t_top();
    t_msg();
    conclude();
  end
endmodule
